// ==== verilog/bsf_defs.svh ====
// bsf_defs.svh: offsets, preset thresholds, reset values and counts for the
// bidirectional queue block; included by the package and the top module.
`ifndef BSF_DEFS_SVH
`define BSF_DEFS_SVH
// data width of each port and of each mailbox
`define BSF_DW 36
// queue depth and pointer width
`define BSF_DEPTH 16384
`define BSF_AW 14
// presets picked by offset_select_1/offset_select_0 = 01, 10, 11
`define BSF_PRESET_01 15'h0008
`define BSF_PRESET_10 15'h0010
`define BSF_PRESET_11 15'h0040
// offsets held before any reset release has selected one
`define BSF_OFF_RESET 15'h0008
// port clock edges needed, per port, while a queue reset is low
`define BSF_RST_EDGES 3'h4
// pin sample stages at reset: port deselected, clock low
`define BSF_PIN_IDLE 41'h8000000000
// static pin stages at reset: both queue resets at their idle high level
`define BSF_MISC_IDLE 5'h18
`endif

// ==== verilog/bsf_pkg.sv ====
// bsf_pkg: types shared by the bidirectional queue block.
// assumes bsf_defs.svh sits on the include path.
package bsf_pkg;
`include "bsf_defs.svh"
   // one port's pin inputs, sampled together
   typedef struct packed {
      logic clk;
      logic select_n;
      logic enable;
      logic direction;
      logic mailbox_select;
      logic [`BSF_DW-1:0] data;
   } bsf_port_in_t;
   // shared static pins
   typedef struct packed {
      logic [1:0] queue_reset_n;
      logic [1:0] offset_select;
      logic timing_mode_select;
   } bsf_misc_t;
   // the four status outputs of one port
   typedef struct packed {
      logic full_or_in_ready;
      logic empty_or_out_ready;
      logic near_full_n;
      logic near_empty_n;
   } bsf_flags_t;
   // offset loader, gray from LD_IDLE through LD_W3
   typedef enum logic [2:0] {
      LD_IDLE = 3'b000,
      LD_W0 = 3'b001,
      LD_W1 = 3'b011,
      LD_W2 = 3'b010,
      LD_W3 = 3'b110
   } bsf_load_t;
endpackage

// ==== verilog/bsf_bidir_queue.sv ====
// bsf_bidir_queue: two opposing queues with mailboxes behind ports A and B.
// assumes all port pins, port clocks and resets are asynchronous to
// i_core_clk, which runs well above both port clocks.
// Operation
// RULE1: port A acts on edge, select low, enable high
// RULE2: port B likewise; data floats while deselected
// RULE3: port A direction high writes, low reads
// RULE4: port B direction low writes, high reads
// RULE5: port A flags change on port A edges
// RULE6: port B flags change on port B edges
// RULE7: timing mode high standard, low fall-through
// RULE8: host keeps timing mode static
// RULE9: port A empty/ready follows B-to-A queue
// RULE10: port B empty/ready follows A-to-B queue
// RULE11: port A full/ready follows A-to-B queue
// RULE12: port B full/ready follows B-to-A queue
// RULE13: reset release latches offset select, picks preset
// RULE14: both released, selects low: four writes load
// RULE15: A-to-B reset needs four edges each clock
// RULE16: B-to-A reset likewise, latches its offsets
// RULE17: port A mailbox select reads B-to-A mailbox
// RULE18: port B mailbox select reads A-to-B mailbox
// RULE19: A-to-B mailbox write lowers flag, blocks rewrites
// RULE20: port B mailbox read or reset raises flag
// RULE21: B-to-A mailbox write lowers flag, blocks rewrites
// RULE22: port A mailbox read or reset raises flag
// RULE23: near-empty low when words at/below offset
// RULE24: near-full low when free at/below offset
// RULE25: presets are 8, 16 or 64
// RULE26: flags pass two stages on port clock
// RULE27: select code to preset mapping fixed
`timescale 1ns/1ps
`include "bsf_defs.svh"
module bsf_bidir_queue
(
   // core clock and reset
   input wire logic i_core_clk,
   input wire logic i_nrst,
   // port pins in
   input wire bsf_pkg::bsf_port_in_t i_port_a,
   input wire bsf_pkg::bsf_port_in_t i_port_b,
   // resets and static selects
   input wire logic i_a_to_b_queue_reset_n,
   input wire logic i_b_to_a_queue_reset_n,
   input wire logic i_timing_mode_select,
   input wire logic i_offset_select_0,
   input wire logic i_offset_select_1,
   // port data out
   output logic [`BSF_DW-1:0] o_port_a_data,
   output logic o_port_a_data_oe,
   output logic [`BSF_DW-1:0] o_port_b_data,
   output logic o_port_b_data_oe,
   // status
   output bsf_pkg::bsf_flags_t o_port_a_flags,
   output bsf_pkg::bsf_flags_t o_port_b_flags,
   output logic o_a_to_b_mail_flag_n,
   output logic o_b_to_a_mail_flag_n
);
   import bsf_pkg::*;

   // index 0: port A, A-to-B queue; index 1: port B, B-to-A queue
   bsf_port_in_t pin [2];
   bsf_port_in_t s1_reg [2];
   bsf_port_in_t s2_reg [2];
   bsf_port_in_t s3_reg [2];
   bsf_misc_t misc_in;
   bsf_misc_t m1_reg;
   bsf_misc_t m2_reg;
   bsf_misc_t m3_reg;
   logic [1:0] edge_p;
   logic [1:0] wr_p;
   logic [1:0] rd_p;
   logic [1:0] mb_p;
   logic [1:0] rst_rise;
   logic [1:0] live;
   logic std_mode;
   logic [`BSF_DW-1:0] q_out [2];
   logic [`BSF_DW-1:0] mbox [2];
   logic [1:0] mflag_n;
   logic [14:0] ae_off_reg [2];
   logic [14:0] af_off_reg [2];
   logic [14:0] preset;
   bsf_load_t load_reg;
   bsf_flags_t flags [2];
   logic [`BSF_DW-1:0] dout_reg [2];
   logic [1:0] oe_reg;

   assign pin[0] = i_port_a;
   assign pin[1] = i_port_b;
   assign misc_in = '{queue_reset_n: {i_b_to_a_queue_reset_n, i_a_to_b_queue_reset_n},
                      offset_select: {i_offset_select_1, i_offset_select_0},
                      timing_mode_select: i_timing_mode_select};

   // three-stage sampling of static pins and resets
   always_ff @(posedge i_core_clk or negedge i_nrst)
   begin
      if (!i_nrst)
      begin
         m1_reg <= `BSF_MISC_IDLE;
         m2_reg <= `BSF_MISC_IDLE;
         m3_reg <= `BSF_MISC_IDLE;
      end
      else
      begin
         m1_reg <= misc_in;
         m2_reg <= m1_reg;
         m3_reg <= m2_reg;
      end
   end

   // mode as seen by the queues
   // RULE7: high selects standard
   assign std_mode = m3_reg.timing_mode_select;

   genvar p;
   generate
      for (p = 0; p < 2; p++)
      begin : g_port
         // pins sampled together on the core clock so they stay aligned
         always_ff @(posedge i_core_clk or negedge i_nrst)
         begin
            if (!i_nrst)
            begin
               s1_reg[p] <= `BSF_PIN_IDLE;
               s2_reg[p] <= `BSF_PIN_IDLE;
               s3_reg[p] <= `BSF_PIN_IDLE;
            end
            else
            begin
               s1_reg[p] <= pin[p];
               s2_reg[p] <= s1_reg[p];
               s3_reg[p] <= s2_reg[p];
            end
         end

         // rising port clock once stage two sees it high while stage three still holds it low
         assign edge_p[p] = s2_reg[p].clk & ~s3_reg[p].clk;
         // RULE1: access needs select low and enable high
         assign mb_p[p] = s3_reg[p].mailbox_select;
         // RULE3: port A writes on direction high
         // RULE4: port B writes on direction low
         assign wr_p[p] = edge_p[p] & ~s3_reg[p].select_n & s3_reg[p].enable
                          & (s3_reg[p].direction ^ 1'(p));
         assign rd_p[p] = edge_p[p] & ~s3_reg[p].select_n & s3_reg[p].enable
                          & ~(s3_reg[p].direction ^ 1'(p));
         assign rst_rise[p] = m2_reg.queue_reset_n[p] & ~m3_reg.queue_reset_n[p];

         // output driver: enable only while selected and reading
         always_ff @(posedge i_core_clk or negedge i_nrst)
         begin
            if (!i_nrst)
            begin
               oe_reg[p] <= 1'b0;
               dout_reg[p] <= '0;
            end
            else
            begin
               // RULE2: float while deselected or writing
               oe_reg[p] <= ~s3_reg[p].select_n & ~(s3_reg[p].direction ^ 1'(p));
               // RULE17: mailbox select picks mailbox over queue
               // RULE18: port B reads A-to-B mailbox
               dout_reg[p] <= mb_p[p] ? mbox[1-p] : q_out[1-p];
            end
         end
      end
   endgenerate

   genvar d;
   generate
      for (d = 0; d < 2; d++)
      begin : g_queue
         logic [`BSF_DW-1:0] mem [`BSF_DEPTH];
         logic [`BSF_AW-1:0] wptr_reg;
         logic [`BSF_AW-1:0] rptr_reg;
         logic [`BSF_AW:0] cnt_reg;
         logic [`BSF_DW-1:0] outr_reg;
         logic outv_reg;
         logic [2:0] edge_a_reg;
         logic [2:0] edge_b_reg;
         logic live_reg;
         logic [`BSF_DW-1:0] mbox_reg;
         logic mflag_n_reg;
         logic push;
         logic pop;
         logic is_full;
         logic is_empty;
         logic [15:0] words;
         logic [15:0] space;
         bsf_flags_t raw;
         bsf_flags_t wst1_reg;
         bsf_flags_t wst2_reg;
         bsf_flags_t a_to_b_queue_reset_n_reg;
         bsf_flags_t b_to_a_queue_reset_n_reg;

         // RULE15: four edges of each port clock while low
         // RULE16: same count gates the B-to-A queue
         always_ff @(posedge i_core_clk or negedge i_nrst)
         begin
            if (!i_nrst)
            begin
               edge_a_reg <= '0;
               edge_b_reg <= '0;
               live_reg <= 1'b0;
            end
            else if (!m3_reg.queue_reset_n[d])
            begin
               live_reg <= 1'b0;
               if (edge_p[0] && edge_a_reg != `BSF_RST_EDGES)
                  edge_a_reg <= edge_a_reg + 3'h1;
               if (edge_p[1] && edge_b_reg != `BSF_RST_EDGES)
                  edge_b_reg <= edge_b_reg + 3'h1;
            end
            else
            begin
               // too short a reset leaves the queue held until the next one
               if (edge_a_reg == `BSF_RST_EDGES && edge_b_reg == `BSF_RST_EDGES)
                  live_reg <= 1'b1;
               edge_a_reg <= '0;
               edge_b_reg <= '0;
            end
         end
         assign live[d] = live_reg;

         assign is_full = (cnt_reg == (`BSF_AW+1)'(`BSF_DEPTH));
         assign is_empty = (cnt_reg == '0);
         // offset loading swallows port A queue writes
         assign push = live_reg & wr_p[d] & ~mb_p[d] & ~is_full
                       & ~(d == 0 && load_reg != LD_IDLE);
         // RULE9: fall-through refills the output word on its own
         assign pop = live_reg & ~is_empty & (std_mode ? (rd_p[1-d] & ~mb_p[1-d])
                      : (~outv_reg | (rd_p[1-d] & ~mb_p[1-d])));

         // storage array
         always_ff @(posedge i_core_clk)
         begin
            if (push)
               mem[wptr_reg] <= s3_reg[d].data;
         end

         // pointers, count and output word
         always_ff @(posedge i_core_clk or negedge i_nrst)
         begin
            if (!i_nrst)
            begin
               wptr_reg <= '0;
               rptr_reg <= '0;
               cnt_reg <= '0;
               outr_reg <= '0;
               outv_reg <= 1'b0;
            end
            else if (!live_reg)
            begin
               wptr_reg <= '0;
               rptr_reg <= '0;
               cnt_reg <= '0;
               outv_reg <= 1'b0;
            end
            else
            begin
               if (push)
                  wptr_reg <= wptr_reg + (`BSF_AW)'(1);
               if (pop)
               begin
                  rptr_reg <= rptr_reg + (`BSF_AW)'(1);
                  outr_reg <= mem[rptr_reg];
                  outv_reg <= 1'b1;
               end
               else if (!std_mode && rd_p[1-d] && !mb_p[1-d])
                  outv_reg <= 1'b0;
               cnt_reg <= cnt_reg + (`BSF_AW+1)'(push) - (`BSF_AW+1)'(pop);
            end
         end
         assign q_out[d] = outr_reg;

         // raw flag levels before the two port-clock stages
         assign words = {1'b0, cnt_reg} + {15'h0, ~std_mode & outv_reg};
         assign space = 16'(`BSF_DEPTH) - {1'b0, cnt_reg};
         always_comb
         begin
            // RULE11: full pin low when full or held in reset
            raw.full_or_in_ready = live_reg & ~is_full;
            // RULE10: empty in standard, word present in fall-through
            raw.empty_or_out_ready = std_mode ? ~is_empty : outv_reg;
            // RULE24: free space at or below offset
            raw.near_full_n = live_reg & (space > {1'b0, af_off_reg[d]});
            // RULE23: words at or below offset
            raw.near_empty_n = words > {1'b0, ae_off_reg[d]};
         end

         // RULE26: two stages on the writer's and the reader's clock
         always_ff @(posedge i_core_clk or negedge i_nrst)
         begin
            if (!i_nrst)
            begin
               wst1_reg <= '0;
               wst2_reg <= '0;
               a_to_b_queue_reset_n_reg <= '0;
               b_to_a_queue_reset_n_reg <= '0;
            end
            else
            begin
               if (edge_p[d])
               begin
                  wst1_reg <= raw;
                  wst2_reg <= wst1_reg;
               end
               if (edge_p[1-d])
               begin
                  a_to_b_queue_reset_n_reg <= raw;
                  b_to_a_queue_reset_n_reg <= a_to_b_queue_reset_n_reg;
               end
            end
         end

         // RULE5: port flags built from registers of its own edges
         // RULE6: same arrangement on port B
         // RULE12: writer port carries full and near-full
         assign flags[d] = '{full_or_in_ready: wst2_reg.full_or_in_ready,
                             near_full_n: wst2_reg.near_full_n,
                             empty_or_out_ready: g_queue[1-d].b_to_a_queue_reset_n_reg.empty_or_out_ready,
                             near_empty_n: g_queue[1-d].b_to_a_queue_reset_n_reg.near_empty_n};

         // mailbox from the writer port to the reader port
         always_ff @(posedge i_core_clk or negedge i_nrst)
         begin
            if (!i_nrst)
            begin
               mbox_reg <= '0;
               mflag_n_reg <= 1'b1;
            end
            // RULE20: queue reset raises the flag
            else if (!m3_reg.queue_reset_n[d])
               mflag_n_reg <= 1'b1;
            // RULE19: write only while flag high, then lower it
            // RULE21: same blocking for B-to-A mailbox
            else if (wr_p[d] && mb_p[d] && mflag_n_reg)
            begin
               mbox_reg <= s3_reg[d].data;
               mflag_n_reg <= 1'b0;
            end
            // RULE22: reader mailbox read raises the flag
            else if (rd_p[1-d] && mb_p[1-d])
               mflag_n_reg <= 1'b1;
         end
         assign mbox[d] = mbox_reg;
         assign mflag_n[d] = mflag_n_reg;
      end
   endgenerate

   // RULE25: presets of 8, 16 and 64
   // RULE27: fixed code to preset mapping
   always_comb
   begin
      unique case (m3_reg.offset_select)
         2'b01: preset = `BSF_PRESET_01;
         2'b10: preset = `BSF_PRESET_10;
         2'b11: preset = `BSF_PRESET_11;
         default: preset = `BSF_OFF_RESET;
      endcase
   end

   // offsets: preset latch at release, or four port A writes
   always_ff @(posedge i_core_clk or negedge i_nrst)
   begin
      if (!i_nrst)
      begin
         ae_off_reg[0] <= `BSF_OFF_RESET;
         ae_off_reg[1] <= `BSF_OFF_RESET;
         af_off_reg[0] <= `BSF_OFF_RESET;
         af_off_reg[1] <= `BSF_OFF_RESET;
         load_reg <= LD_IDLE;
      end
      // RULE14: joint release with selects low starts loading
      else if (rst_rise == 2'b11 && m3_reg.offset_select == 2'b00)
         load_reg <= LD_W0;
      else
      begin
         // RULE13: release with a nonzero select takes a preset
         for (int i = 0; i < 2; i++)
         begin
            if (rst_rise[i] && m3_reg.offset_select != 2'b00)
            begin
               ae_off_reg[i] <= preset;
               af_off_reg[i] <= preset;
            end
         end
         // RULE14: each loading write fills the next offset
         if (wr_p[0] && !mb_p[0] && live[0])
         begin
            unique case (load_reg)
               LD_IDLE: ;
               LD_W0:
               begin
                  ae_off_reg[0] <= s3_reg[0].data[14:0];
                  load_reg <= LD_W1;
               end
               LD_W1:
               begin
                  ae_off_reg[1] <= s3_reg[0].data[14:0];
                  load_reg <= LD_W2;
               end
               LD_W2:
               begin
                  af_off_reg[0] <= s3_reg[0].data[14:0];
                  load_reg <= LD_W3;
               end
               LD_W3:
               begin
                  af_off_reg[1] <= s3_reg[0].data[14:0];
                  load_reg <= LD_IDLE;
               end
            endcase
         end
      end
   end

   // port outputs
   assign o_port_a_data = dout_reg[0];
   assign o_port_b_data = dout_reg[1];
   assign o_port_a_data_oe = oe_reg[0];
   assign o_port_b_data_oe = oe_reg[1];
   assign o_port_a_flags = flags[0];
   assign o_port_b_flags = flags[1];
   assign o_a_to_b_mail_flag_n = mflag_n[0];
   assign o_b_to_a_mail_flag_n = mflag_n[1];

endmodule // bsf_bidir_queue

// ==== verif/bsf_chk.sv ====
// bsf_chk: port-level assertions for bsf_bidir_queue.
// assumes pins change on core edges and stay put around each port edge.
`timescale 1ns/1ps
module bsf_chk
(
   // clock and reset
   input wire logic i_core_clk,
   input wire logic i_nrst,
   // port pins and queue resets
   input wire bsf_pkg::bsf_port_in_t i_port_a,
   input wire bsf_pkg::bsf_port_in_t i_port_b,
   input wire logic i_a_to_b_queue_reset_n,
   input wire logic i_b_to_a_queue_reset_n,
   // watched outputs
   input wire logic o_port_a_data_oe,
   input wire logic o_port_b_data_oe,
   input wire bsf_pkg::bsf_flags_t o_port_a_flags,
   input wire bsf_pkg::bsf_flags_t o_port_b_flags,
   input wire logic o_a_to_b_mail_flag_n,
   input wire logic o_b_to_a_mail_flag_n
);
   import bsf_pkg::*;
   default clocking cb @(posedge i_core_clk); endclocking
   default disable iff (!i_nrst);
   logic clk_a_reg;
   logic [3:0] since_a_reg;
   // core cycles since the last port A clock rise
   always_ff @(posedge i_core_clk or negedge i_nrst)
   begin
      if (!i_nrst)
      begin
         clk_a_reg <= 1'b0;
         since_a_reg <= 4'h0;
      end
      else
      begin
         clk_a_reg <= i_port_a.clk;
         if (i_port_a.clk && !clk_a_reg)
            since_a_reg <= 4'h0;
         else if (since_a_reg != 4'hf)
            since_a_reg <= since_a_reg + 4'h1;
      end
   end
   // mailbox flags left alone by the far port
   sequence s_ab_quiet;
      (!o_a_to_b_mail_flag_n && i_port_b.select_n && i_a_to_b_queue_reset_n) [*6];
   endsequence
   sequence s_ba_quiet;
      (!o_b_to_a_mail_flag_n && i_port_a.select_n && i_b_to_a_queue_reset_n) [*6];
   endsequence
   a_a_desel_float: assert property (i_port_a.select_n [*5] |-> !o_port_a_data_oe)
      else $error("port A drives bus while deselected");
   a_b_desel_float: assert property (i_port_b.select_n [*5] |-> !o_port_b_data_oe)
      else $error("port B drives bus while deselected");
   a_a_write_float: assert property (i_port_a.direction [*5] |-> !o_port_a_data_oe)
      else $error("port A drives bus in write direction");
   a_b_write_float: assert property (!i_port_b.direction [*5] |-> !o_port_b_data_oe)
      else $error("port B drives bus in write direction");
   a_ab_mail_keep: assert property (s_ab_quiet |=> !o_a_to_b_mail_flag_n)
      else $error("a to b mail flag rose without a read");
   a_ba_mail_keep: assert property (s_ba_quiet |=> !o_b_to_a_mail_flag_n)
      else $error("b to a mail flag rose without a read");
   a_ab_mail_set: assert property ((o_a_to_b_mail_flag_n && i_port_a.select_n) [*6] |=> o_a_to_b_mail_flag_n)
      else $error("a to b mail flag fell without a write");
   a_b_empty_near: assert property (!o_port_b_flags.empty_or_out_ready |-> !o_port_b_flags.near_empty_n)
      else $error("port B near empty high while empty");
   // flags move after port A edges
   a_a_flag_edge: assert property (disable iff (!i_nrst || !i_a_to_b_queue_reset_n || !i_b_to_a_queue_reset_n)
      $changed(o_port_a_flags) |-> since_a_reg < 4'h8)
      else $error("port A flags changed away from a port A edge");
endmodule // bsf_chk

bind bsf_bidir_queue bsf_chk u_chk
(
   .i_core_clk,
   .i_nrst,
   .i_port_a,
   .i_port_b,
   .i_a_to_b_queue_reset_n,
   .i_b_to_a_queue_reset_n,
   .o_port_a_data_oe,
   .o_port_b_data_oe,
   .o_port_a_flags,
   .o_port_b_flags,
   .o_a_to_b_mail_flag_n,
   .o_b_to_a_mail_flag_n
);

// ==== verif/bsf_host.sv ====
// bsf_host: bus master on one port of the queue block.
// assumes the core clock paces it and the bench calls tick per period.
`timescale 1ns/1ps
`include "bsf_defs.svh"
module bsf_host
#(
   parameter logic WR_LEVEL = 1'b1
)
(
   // pacing clock
   input wire logic i_core_clk,
   // pin levels toward the block
   output bsf_pkg::bsf_port_in_t o_port
);
   import bsf_pkg::*;
   // pins idle and deselected at time zero
   initial
   begin
      o_port = '0;
      o_port.select_n = 1'b1;
   end
   // one port clock period carrying one access or none
   task automatic tick(input logic sel_n, input logic en, input logic wr, input logic mb,
                       input logic [`BSF_DW-1:0] d);
      @(posedge i_core_clk);
      o_port.select_n <= sel_n;
      o_port.enable <= en;
      o_port.direction <= wr ? WR_LEVEL : !WR_LEVEL;
      o_port.mailbox_select <= mb;
      o_port.data <= wr ? d : ~o_port.data; // released bus shows no old value
      repeat (5) @(posedge i_core_clk);
      o_port.clk <= 1'b1;
      repeat (4) @(posedge i_core_clk);
      o_port.clk <= 1'b0;
      repeat (6) @(posedge i_core_clk);
   endtask
endmodule // bsf_host

// ==== verif/tb_top.sv ====
// tb_top: self-checking bench for bsf_bidir_queue.
// assumes one bsf_host per port and a 100 MHz core clock.
`timescale 1ns/1ps
`include "bsf_defs.svh"
module tb_top;
   import bsf_pkg::*;
   logic i_core_clk = 1'b0;
   logic i_nrst = 1'b0;
   logic rst_ab_n = 1'b0;
   logic rst_ba_n = 1'b0;
   logic mode = 1'b1;
   logic [1:0] osel = 2'h0;
   bsf_port_in_t pa, pb, pin_a, pin_b;
   logic [`BSF_DW-1:0] da, db, d1;
   logic oe_a, oe_b, mf_ab, mf_ba;
   bsf_flags_t fa, fb;
   logic [`BSF_DW-1:0] qa[$], qb[$];
   int n_fail = 0;
   int n_checks = 0;
   // core clock
   always #5 i_core_clk = ~i_core_clk;
   // masters and the two shared buses
   bsf_host #(.WR_LEVEL(1'b1)) host_a (.i_core_clk(i_core_clk), .o_port(pa));
   bsf_host #(.WR_LEVEL(1'b0)) host_b (.i_core_clk(i_core_clk), .o_port(pb));
   assign pin_a = oe_a ? {pa[40:36], da} : pa;
   assign pin_b = oe_b ? {pb[40:36], db} : pb;
   bsf_bidir_queue dut_u (.i_core_clk(i_core_clk), .i_nrst(i_nrst), .i_port_a(pin_a), .i_port_b(pin_b),
      .i_a_to_b_queue_reset_n(rst_ab_n), .i_b_to_a_queue_reset_n(rst_ba_n), .i_timing_mode_select(mode),
      .i_offset_select_0(osel[0]), .i_offset_select_1(osel[1]), .o_port_a_data(da), .o_port_a_data_oe(oe_a),
      .o_port_b_data(db), .o_port_b_data_oe(oe_b), .o_port_a_flags(fa), .o_port_b_flags(fb),
      .o_a_to_b_mail_flag_n(mf_ab), .o_b_to_a_mail_flag_n(mf_ba));
   // compare helpers, one per kind of result
   task automatic cmp_bit(input string nm, input logic e, input logic g);
      n_checks++;
      if (g !== e)
      begin
         n_fail++;
         $display("FAIL %s expected %b seen %b", nm, e, g);
      end
   endtask
   task automatic cmp_word(input string nm, input logic [`BSF_DW-1:0] e, input logic [`BSF_DW-1:0] g);
      n_checks++;
      if (g !== e)
      begin
         n_fail++;
         $display("FAIL %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", n_checks, n_fail);
      if (n_fail == 0 && n_checks > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   function automatic logic [`BSF_DW-1:0] rw();
      logic [63:0] r;
      r = {$urandom(), $urandom()};
      return r[`BSF_DW-1:0];
   endfunction
   // one access on port a (p=0) or b, noting queue writes
   task automatic xfer(input bit p, input bit wr, input bit mb, input logic [`BSF_DW-1:0] d);
      if (wr && !mb && p)
         qa.push_back(d);
      if (wr && !mb && !p)
         qb.push_back(d);
      if (p)
         host_b.tick(1'b0, 1'b1, wr, mb, d);
      else
         host_a.tick(1'b0, 1'b1, wr, mb, d);
   endtask
   // deselected periods carrying write data that must be ignored
   task automatic idle(input int n);
      fork
         repeat (n) host_a.tick(1'b1, 1'b1, 1'b1, 1'b0, rw());
         repeat (n) host_b.tick(1'b1, 1'b1, 1'b1, 1'b0, rw());
      join
   endtask
   task automatic restart(input logic m, input logic [1:0] s);
      @(posedge i_core_clk);
      i_nrst <= 1'b0;
      rst_ab_n <= 1'b0;
      rst_ba_n <= 1'b0;
      mode <= m;
      osel <= s;
      repeat (6) @(posedge i_core_clk);
      i_nrst <= 1'b1;
      // five edges per port while low
      idle(5);
      @(posedge i_core_clk);
      rst_ab_n <= 1'b1;
      rst_ba_n <= 1'b1;
      idle(4);
      @(negedge i_core_clk);
   endtask
   // read words against the oldest note, after the edge or before it in fall-through
   always @(posedge pa.clk)
      if (!pa.select_n && pa.enable && !pa.direction)
      begin
         repeat (mode ? 9 : 1) @(negedge i_core_clk);
         cmp_word("port a data", qa.pop_front(), da);
         cmp_bit("port a oe", 1'b1, oe_a);
      end
   always @(posedge pb.clk)
      if (!pb.select_n && pb.enable && pb.direction)
      begin
         repeat (mode ? 9 : 1) @(negedge i_core_clk);
         cmp_word("port b data", qb.pop_front(), db);
         cmp_bit("port b oe", 1'b1, oe_b);
      end
   // hang guard, far above the expected run length
   initial
   begin
      #300000;
      n_fail++;
      report_and_stop();
   end
   // main sequence
   initial
   begin
      void'($urandom(63));
      restart(1'b1, 2'h1);
      cmp_bit("ab mail flag", 1'b1, mf_ab);
      cmp_bit("ba mail flag", 1'b1, mf_ba);
      cmp_bit("a in ready", 1'b1, fa.full_or_in_ready);
      cmp_bit("b in ready", 1'b1, fb.full_or_in_ready);
      cmp_bit("b out ready", 1'b0, fb.empty_or_out_ready);
      cmp_bit("b near empty", 1'b0, fb.near_empty_n);
      cmp_bit("a near full", 1'b1, fa.near_full_n);
      cmp_bit("b near full", 1'b1, fb.near_full_n);
      $display("test reset done");
      for (int i = 0; i < 9; i++)
      begin
         if (i == 8)
         begin
            host_a.tick(1'b0, 1'b0, 1'b1, 1'b0, rw());
            idle(4);
            cmp_bit("b near empty", 1'b0, fb.near_empty_n);
         end
         xfer(0, 1, 0, rw());
      end
      idle(4);
      cmp_bit("b near empty", 1'b1, fb.near_empty_n);
      cmp_bit("b out ready", 1'b1, fb.empty_or_out_ready);
      repeat (9) xfer(1, 0, 0, '0);
      repeat (2) xfer(1, 1, 0, rw());
      idle(4);
      repeat (2) xfer(0, 0, 0, '0);
      idle(4);
      cmp_bit("b out ready", 1'b0, fb.empty_or_out_ready);
      $display("test standard queue done");
      for (int p = 0; p < 2; p++)
      begin
         d1 = rw();
         if (p)
            qa.push_back(d1);
         else
            qb.push_back(d1);
         xfer(p, 1, 1, d1);
         xfer(p, 1, 1, ~d1);
         cmp_bit("mail flag", 1'b0, p ? mf_ba : mf_ab);
         xfer(!p, 0, 1, '0);
         idle(1);
         cmp_bit("mail flag", 1'b1, p ? mf_ba : mf_ab);
      end
      $display("test mailbox done");
      // the two larger presets, 16 and 64 words
      for (int s = 2; s < 4; s++)
      begin
         restart(1'b1, 2'(s));
         repeat (s == 2 ? 16 : 64) xfer(0, 1, 0, rw());
         idle(4);
         cmp_bit("b near empty", 1'b0, fb.near_empty_n);
         xfer(0, 1, 0, rw());
         idle(4);
         cmp_bit("b near empty", 1'b1, fb.near_empty_n);
         // the next reset empties the queue, so its notes go too
         qb.delete();
      end
      $display("test presets done");
      restart(1'b0, 2'h0);
      cmp_bit("b out ready", 1'b0, fb.empty_or_out_ready);
      host_a.tick(1'b0, 1'b1, 1'b1, 1'b0, 36'h000000002);
      host_a.tick(1'b0, 1'b1, 1'b1, 1'b0, 36'h000000001);
      host_a.tick(1'b0, 1'b1, 1'b1, 1'b0, 36'h000000005);
      host_a.tick(1'b0, 1'b1, 1'b1, 1'b0, 36'h000000005);
      for (int i = 0; i < 3; i++)
      begin
         xfer(0, 1, 0, rw());
         idle(4);
         cmp_bit("b near empty", i == 2, fb.near_empty_n);
         cmp_bit("b out ready", 1'b1, fb.empty_or_out_ready);
      end
      xfer(1, 1, 0, rw());
      idle(4);
      cmp_bit("a out ready", 1'b1, fa.empty_or_out_ready);
      cmp_bit("a near empty", 1'b0, fa.near_empty_n);
      xfer(0, 0, 0, '0);
      repeat (3) xfer(1, 0, 0, '0);
      idle(4);
      cmp_bit("b out ready", 1'b0, fb.empty_or_out_ready);
      cmp_bit("a out ready", 1'b0, fa.empty_or_out_ready);
      $display("test fall-through done");
      report_and_stop();
   end
endmodule // tb_top
